// File: hdl/npia_packet_input.sv
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "npia_regs.svh"
module npia_packet_input import npia_pkg::*; #(
  parameter int MAX_WORDS = 8,
  parameter logic [15:0] CRC_POLY = `NPIA_CRC_POLY,
  parameter logic [15:0] CRC_INIT = `NPIA_CRC_INIT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxDelim,
  output logic rxReady,
  output logic ackOut,
  output logic nackOut,
  output logic lateReject,
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [63:0] memWdata,
  input wire logic memAck,
  input wire logic [63:0] memRdata,
  output logic errValid,
  output logic [63:0] errData,
  input wire logic errReady,
  input wire logic sendReq,
  input wire logic [15:0] sendVp,
  input wire logic ctxChange,
  input wire logic [31:0] ctxBlockAddr,
  output logic lkReq,
  output logic [31:0] lkAddr,
  input wire logic lkAck,
  input wire logic [63:0] lkRdata,
  output logic lkBusy,
  output logic sendDone,
  output logic [15:0] sendProc,
  output logic [15:0] sendCtx,
  output logic [31:0] sendRouteAddr,
  output logic nullRouteTrap
);
  localparam int IW = $clog2(MAX_WORDS) + 1;

  npia_rx_state_type state_ff;
  logic [63:0] words_ff [MAX_WORDS];
  logic [55:0] shift_ff;
  logic [2:0] byteCnt_ff;
  logic [IW-1:0] wordIdx_ff;
  logic [IW-1:0] lastIdx_ff;
  logic [IW-1:0] execIdx_ff;
  logic [15:0] crc_ff;
  logic crcHalf_ff;
  logic acked_ff;
  logic errMode_ff;
  logic [1:0] ctrl_ff;
  logic [15:0] filter_ff;
  logic [31:0] routeBase_ff;
  logic [15:0] ackCnt_ff;
  logic [15:0] nackCnt_ff;
  logic wbAck_ff;
  logic [31:0] wbDat_ff;
  logic [63:0] nxt_word;
  logic [15:0] nxt_crc;
  logic take;
  logic isData;
  logic [63:0] hdr;
  logic rejectNow;
  logic wbWrite;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] val,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign rxReady = (state_ff == RX_HUNT) || (state_ff == RX_COLLECT)
                 || (state_ff == RX_CRC) || (state_ff == RX_DRAIN);
  assign take = rxValid && rxReady;
  assign isData = take && !rxDelim;
  assign nxt_word = {shift_ff, rxData};
  assign nxt_crc = crcStep(crc_ff, rxData);
  assign hdr = words_ff[0];
  // verdict taken on the second crc byte: good crc residue is zero
  assign rejectNow = (nxt_crc != 16'h0) || ctrl_ff[`NPIA_CTRL_BUSY_BIT]
                   || (ctrl_ff[`NPIA_CTRL_FILTER_EN_BIT]
                       && hdr[`NPIA_HDR_CTX_MSB:`NPIA_HDR_CTX_LSB] == filter_ff);

  // receive, execute and respond; one transaction at a time keeps order
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= RX_HUNT;
      shift_ff <= 56'h0;
      byteCnt_ff <= 3'h0;
      wordIdx_ff <= '0;
      lastIdx_ff <= '0;
      execIdx_ff <= '0;
      crc_ff <= CRC_INIT;
      crcHalf_ff <= 1'b0;
      acked_ff <= 1'b0;
      errMode_ff <= 1'b0;
      ackOut <= 1'b0;
      nackOut <= 1'b0;
      lateReject <= 1'b0;
      memReq <= 1'b0;
      memWe <= 1'b0;
      memAddr <= 32'h0;
      memWdata <= 64'h0;
      errValid <= 1'b0;
      errData <= 64'h0;
    end else begin
      ackOut <= 1'b0;
      nackOut <= 1'b0;
      lateReject <= 1'b0;
      unique case (state_ff)
        RX_HUNT: begin
          if (take && rxDelim && rxData == `NPIA_DELIM_START) begin
            state_ff <= RX_COLLECT;
            acked_ff <= 1'b0;
            errMode_ff <= 1'b0;
            byteCnt_ff <= 3'h0;
            wordIdx_ff <= '0;
            crc_ff <= CRC_INIT;
          end
        end
        RX_COLLECT: begin
          if (take && rxDelim) begin
            state_ff <= (rxData == `NPIA_DELIM_END) ? RX_HUNT : RX_DRAIN;
            if (byteCnt_ff != 3'h0 || wordIdx_ff != '0) begin
              // truncated transaction counts as a reject
              if (acked_ff) begin
                lateReject <= 1'b1;
              end else begin
                nackOut <= 1'b1;
              end
            end else if (!acked_ff) begin
              nackOut <= 1'b1;
            end
          end else if (isData) begin
            crc_ff <= nxt_crc;
            shift_ff <= nxt_word[55:0];
            byteCnt_ff <= byteCnt_ff + 3'h1;
            if (byteCnt_ff == 3'h7) begin
              words_ff[wordIdx_ff[IW-2:0]] <= nxt_word;
              wordIdx_ff <= wordIdx_ff + 1'b1;
              if (wordIdx_ff == '0) begin
                lastIdx_ff <= IW'(nxt_word[`NPIA_HDR_LEN_MSB:`NPIA_HDR_LEN_LSB]);
                if (nxt_word[`NPIA_HDR_LEN_MSB:`NPIA_HDR_LEN_LSB] == 3'h0) begin
                  state_ff <= RX_CRC;
                  crcHalf_ff <= 1'b0;
                end
              end else if (wordIdx_ff == lastIdx_ff) begin
                state_ff <= RX_CRC;
                crcHalf_ff <= 1'b0;
              end
            end
          end
        end
        RX_CRC: begin
          if (take && rxDelim) begin
            state_ff <= (rxData == `NPIA_DELIM_END) ? RX_HUNT : RX_DRAIN;
            if (acked_ff) begin
              lateReject <= 1'b1;
            end else begin
              nackOut <= 1'b1;
            end
          end else if (isData) begin
            crc_ff <= nxt_crc;
            crcHalf_ff <= 1'b1;
            if (crcHalf_ff) begin
              crc_ff <= CRC_INIT;
              wordIdx_ff <= '0;
              byteCnt_ff <= 3'h0;
              if (rejectNow && !acked_ff) begin
                nackOut <= 1'b1;
                state_ff <= RX_DRAIN;
              end else begin
                if (rejectNow) begin
                  lateReject <= 1'b1;
                  errMode_ff <= 1'b1;
                end
                state_ff <= RX_EXEC;
                execIdx_ff <= (rejectNow || errMode_ff) ? '0 : IW'(1);
              end
            end
          end
        end
        RX_EXEC: begin
          if (errMode_ff) begin
            // diverted: every word including the header goes to the error buffer
            if (errValid) begin
              if (errReady) begin
                errValid <= 1'b0;
                execIdx_ff <= execIdx_ff + 1'b1;
              end
            end else if (execIdx_ff > lastIdx_ff) begin
              state_ff <= RX_COLLECT;
            end else begin
              errValid <= 1'b1;
              errData <= words_ff[execIdx_ff[IW-2:0]];
            end
          end else if (hdr[63:56] == TX_COND && execIdx_ff == IW'(1)) begin
            state_ff <= RX_CONDRD;
            memReq <= 1'b1;
            memWe <= 1'b0;
            memAddr <= hdr[31:0];
          end else if (memReq) begin
            if (memAck) begin
              memReq <= 1'b0;
              execIdx_ff <= execIdx_ff + 1'b1;
            end
          end else if (execIdx_ff > lastIdx_ff || hdr[63:56] != TX_WRITE) begin
            // done; ack only once all of this transaction has landed
            state_ff <= RX_COLLECT;
            if (hdr[`NPIA_HDR_ACKPT_BIT] && !acked_ff) begin
              ackOut <= 1'b1;
              acked_ff <= 1'b1;
            end
          end else begin
            memReq <= 1'b1;
            memWe <= 1'b1;
            memAddr <= hdr[31:0] + {execIdx_ff - 1'b1, 3'h0};
            memWdata <= words_ff[execIdx_ff[IW-2:0]];
          end
        end
        RX_CONDRD: begin
          if (memAck) begin
            memReq <= 1'b0;
            if (memRdata == words_ff[1]) begin
              state_ff <= RX_EXEC;
              execIdx_ff <= lastIdx_ff + 1'b1;
            end else if (acked_ff) begin
              lateReject <= 1'b1;
              errMode_ff <= 1'b1;
              state_ff <= RX_EXEC;
              execIdx_ff <= '0;
            end else begin
              nackOut <= 1'b1;
              state_ff <= RX_DRAIN;
            end
          end
        end
        RX_DRAIN: begin
          if (take && rxDelim && rxData == `NPIA_DELIM_END) begin
            state_ff <= RX_HUNT;
          end
        end
        default: begin
          state_ff <= RX_HUNT;
        end
      endcase
    end
  end

  assign wbWrite = cyc_i && stb_i && we_i && !wbAck_ff;

  // single wait state slave; unmapped reads return zero and still ack
  always_ff @(posedge clk) begin
    if (reset) begin
      wbAck_ff <= 1'b0;
      wbDat_ff <= 32'h0;
      ctrl_ff <= `NPIA_CTRL_RESET;
      filter_ff <= `NPIA_FILTER_RESET;
      routeBase_ff <= `NPIA_ROUTE_BASE_RESET;
    end else begin
      wbAck_ff <= cyc_i && stb_i && !wbAck_ff;
      if (wbWrite) begin
        unique case (adr_i)
          `NPIA_CTRL_OFS: ctrl_ff <= 2'(laneMerge({30'h0, ctrl_ff}, dat_i, sel_i));
          `NPIA_FILTER_OFS: filter_ff <= 16'(laneMerge({16'h0, filter_ff}, dat_i, sel_i));
          `NPIA_ROUTE_BASE_OFS: routeBase_ff <= laneMerge(routeBase_ff, dat_i, sel_i);
          default: begin
          end
        endcase
      end
      unique case (adr_i)
        `NPIA_CTRL_OFS: wbDat_ff <= {30'h0, ctrl_ff};
        `NPIA_FILTER_OFS: wbDat_ff <= {16'h0, filter_ff};
        `NPIA_ROUTE_BASE_OFS: wbDat_ff <= routeBase_ff;
        `NPIA_STATUS_OFS: wbDat_ff <= {26'h0, errMode_ff, acked_ff, lkBusy, state_ff};
        `NPIA_COUNT_OFS: wbDat_ff <= {nackCnt_ff, ackCnt_ff};
        default: wbDat_ff <= 32'h0;
      endcase
    end
  end

  assign ack_o = wbAck_ff;
  assign dat_o = wbDat_ff;

  // counters wrap; software reads differences
  always_ff @(posedge clk) begin
    if (reset) begin
      ackCnt_ff <= 16'h0;
      nackCnt_ff <= 16'h0;
    end else begin
      ackCnt_ff <= ackCnt_ff + {15'h0, ackOut};
      nackCnt_ff <= nackCnt_ff + {15'h0, nackOut};
    end
  end

  npia_route_lookup u_lookup (
    .clk(clk),
    .reset(reset),
    .sendReq(sendReq),
    .sendVp(sendVp),
    .ctxChange(ctxChange),
    .ctxBlockAddr(ctxBlockAddr),
    .routeBase(routeBase_ff),
    .lkReq(lkReq),
    .lkAddr(lkAddr),
    .lkAck(lkAck),
    .lkRdata(lkRdata),
    .lkBusy(lkBusy),
    .sendDone(sendDone),
    .sendProc(sendProc),
    .sendCtx(sendCtx),
    .sendRouteAddr(sendRouteAddr),
    .nullRouteTrap(nullRouteTrap)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_oneResponse;
    (ackOut || nackOut) |-> !(ackOut && nackOut) && !$past(acked_ff);
  endproperty
  a_oneResponse: assert property (p_oneResponse) else $error("second response in packet");

  property p_huntDiscard;
    state_ff == RX_HUNT && take && !rxDelim |=> state_ff == RX_HUNT;
  endproperty
  a_huntDiscard: assert property (p_huntDiscard) else $error("route byte not dropped");

  property p_ackAfterExec;
    ackOut |-> $past(state_ff) == RX_EXEC && $past(hdr[`NPIA_HDR_ACKPT_BIT]) && !memReq;
  endproperty
  a_ackAfterExec: assert property (p_ackAfterExec) else $error("ack before execution");

  property p_crcNack;
    state_ff == RX_CRC && crcHalf_ff && isData && nxt_crc != 16'h0 && !acked_ff
      |=> nackOut && state_ff == RX_DRAIN;
  endproperty
  a_crcNack: assert property (p_crcNack) else $error("bad crc not nacked");

  property p_lateDivert;
    state_ff == RX_CRC && crcHalf_ff && isData && rejectNow && acked_ff
      |=> lateReject && errMode_ff && !nackOut;
  endproperty
  a_lateDivert: assert property (p_lateDivert) else $error("late reject mishandled");

  property p_filterNack;
    state_ff == RX_CRC && crcHalf_ff && isData && !acked_ff && ctrl_ff[1]
      && hdr[47:32] == filter_ff |=> nackOut;
  endproperty
  a_filterNack: assert property (p_filterNack) else $error("filtered context not nacked");

  property p_memHold;
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWdata);
  endproperty
  a_memHold: assert property (p_memHold) else $error("memory request changed early");

  property p_errOnlyDiverted;
    errValid |-> errMode_ff && acked_ff;
  endproperty
  a_errOnlyDiverted: assert property (p_errOnlyDiverted) else $error("error push without ack");

  property p_wbAck;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_wbAck: assert property (p_wbAck) else $error("bus ack timing wrong");

  c_ack: cover property (ackOut);
  c_nack: cover property (nackOut);
  c_late: cover property (lateReject ##[1:40] errValid);
endmodule

// File: hdl/npia_pkg.sv
package npia_pkg;

  typedef enum logic [2:0] {
    RX_HUNT = 3'b000,
    RX_COLLECT = 3'b001,
    RX_CRC = 3'b011,
    RX_EXEC = 3'b010,
    RX_CONDRD = 3'b110,
    RX_DRAIN = 3'b100
  } npia_rx_state_type;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_CTX = 2'b01,
    LK_VPT = 2'b11,
    LK_ROUTE = 2'b10
  } npia_lk_state_type;

  typedef enum logic [7:0] {
    TX_WRITE = 8'h01,
    TX_COND = 8'h02
  } npia_txn_type;

endpackage

// File: hdl/npia_regs.svh
`ifndef NPIA_REGS_SVH
`define NPIA_REGS_SVH

// register offsets, byte addresses on the wishbone port
`define NPIA_CTRL_OFS 8'h00
`define NPIA_FILTER_OFS 8'h04
`define NPIA_ROUTE_BASE_OFS 8'h08
`define NPIA_STATUS_OFS 8'h0c
`define NPIA_COUNT_OFS 8'h10

// control fields and reset values
`define NPIA_CTRL_BUSY_BIT 0
`define NPIA_CTRL_FILTER_EN_BIT 1
`define NPIA_CTRL_RESET 2'h0
`define NPIA_FILTER_RESET 16'h0000
`define NPIA_ROUTE_BASE_RESET 32'h0000_0000

// link delimiter codes, carried with rxDelim high
`define NPIA_DELIM_START 8'h01
`define NPIA_DELIM_END 8'h02

// transaction header layout of the first double word
`define NPIA_HDR_TYPE_MSB 63
`define NPIA_HDR_TYPE_LSB 56
`define NPIA_HDR_ACKPT_BIT 55
`define NPIA_HDR_LEN_MSB 50
`define NPIA_HDR_LEN_LSB 48
`define NPIA_HDR_CTX_MSB 47
`define NPIA_HDR_CTX_LSB 32
`define NPIA_HDR_ADDR_MSB 31
`define NPIA_HDR_ADDR_LSB 0

// crc defaults, both ends must agree
`define NPIA_CRC_POLY 16'h1021
`define NPIA_CRC_INIT 16'hffff

// route table geometry
`define NPIA_ROUTES_PER_DEST 4
`define NPIA_ROUTE_ENTRY_SHIFT 4
`define NPIA_DEST_STRIDE_SHIFT 6
`define NPIA_VPT_ENTRY_SHIFT 3
`define NPIA_LFSR_SEED 16'hace1

`endif

// File: hdl/npia_route_lookup.sv
`timescale 1ns/1ps
`include "npia_regs.svh"
module npia_route_lookup import npia_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic sendReq,
  input wire logic [15:0] sendVp,
  input wire logic ctxChange,
  input wire logic [31:0] ctxBlockAddr,
  input wire logic [31:0] routeBase,
  output logic lkReq,
  output logic [31:0] lkAddr,
  input wire logic lkAck,
  input wire logic [63:0] lkRdata,
  output logic lkBusy,
  output logic sendDone,
  output logic [15:0] sendProc,
  output logic [15:0] sendCtx,
  output logic [31:0] sendRouteAddr,
  output logic nullRouteTrap
);
  npia_lk_state_type state_ff;
  logic [31:0] vptBase_ff;
  logic [15:0] lfsr_ff;
  logic [31:0] nxt_routeAddr;

  // free running, so the pick does not track request timing
  always_ff @(posedge clk) begin
    if (reset) begin
      lfsr_ff <= `NPIA_LFSR_SEED;
    end else begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
    end
  end

  always_comb begin
    nxt_routeAddr = routeBase + {10'h0, lkRdata[31:16], 6'h0}
                  + {26'h0, lfsr_ff[1:0], 4'h0};
  end

  assign lkBusy = (state_ff != LK_IDLE);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= LK_IDLE;
      vptBase_ff <= 32'h0;
      lkReq <= 1'b0;
      lkAddr <= 32'h0;
      sendDone <= 1'b0;
      nullRouteTrap <= 1'b0;
      sendProc <= 16'h0;
      sendCtx <= 16'h0;
      sendRouteAddr <= 32'h0;
    end else begin
      sendDone <= 1'b0;
      nullRouteTrap <= 1'b0;
      unique case (state_ff)
        LK_IDLE: begin
          if (ctxChange) begin
            state_ff <= LK_CTX;
            lkReq <= 1'b1;
            lkAddr <= ctxBlockAddr;
          end else if (sendReq) begin
            state_ff <= LK_VPT;
            lkReq <= 1'b1;
            lkAddr <= vptBase_ff + {13'h0, sendVp, 3'h0};
          end
        end
        LK_CTX: begin
          if (lkAck) begin
            vptBase_ff <= lkRdata[31:0];
            lkReq <= 1'b0;
            state_ff <= LK_IDLE;
          end
        end
        LK_VPT: begin
          if (lkAck) begin
            sendProc <= lkRdata[31:16];
            sendCtx <= lkRdata[15:0];
            lkAddr <= nxt_routeAddr;
            sendRouteAddr <= nxt_routeAddr;
            state_ff <= LK_ROUTE;
          end
        end
        LK_ROUTE: begin
          if (lkAck) begin
            lkReq <= 1'b0;
            state_ff <= LK_IDLE;
            if (lkRdata[63:56] == 8'h00) begin
              nullRouteTrap <= 1'b1;
            end else begin
              sendDone <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_nullTrap;
    state_ff == LK_ROUTE && lkAck && lkRdata[63:56] == 8'h00 |=> nullRouteTrap && !sendDone;
  endproperty
  a_nullTrap: assert property (p_nullTrap) else $error("null route not trapped");

  property p_routeStride;
    sendDone |-> sendRouteAddr[3:0] == 4'h0 && ((sendRouteAddr - routeBase) >> 6) == {16'h0, sendProc};
  endproperty
  a_routeStride: assert property (p_routeStride) else $error("route entry misplaced");

  c_nullTrap: cover property (nullRouteTrap);
endmodule

// File: test/npia_link_sender.sv
`timescale 1ns/1ps
module npia_link_sender (
  input wire logic clk,
  input wire logic rxReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxDelim
);
  initial begin
    rxValid = 1'b0;
    rxData = 8'h5a;
    rxDelim = 1'b0;
  end
  // byte held until taken; sometimes pauses so slow senders are seen too
  task automatic put(input logic dl, input logic [7:0] b);
    rxValid <= 1'b1;
    rxData <= b;
    rxDelim <= dl;
    @(posedge clk iff rxReady);
    if ($urandom_range(0, 2) == 0) begin
      rxValid <= 1'b0;
      rxDelim <= 1'b0;
      rxData <= ~b;
      @(posedge clk);
    end
  endtask
  // released line inverts rxData, so after a paused put it shows the last byte again
  task automatic rest();
    rxValid <= 1'b0;
    rxDelim <= 1'b0;
    rxData <= ~rxData;
    @(posedge clk);
  endtask
endmodule

// File: test/test_npia_packet_input.sv
`timescale 1ns/1ps
`include "npia_regs.svh"
module test_npia_packet_input;
  import npia_pkg::*;
  logic clk, reset, we_i, stb_i, cyc_i, ack_o, rxValid, rxDelim, rxReady, ackOut, nackOut;
  logic lateReject, memReq, memWe, memAck, errValid, errReady, sendReq, ctxChange;
  logic lkReq, lkAck, lkBusy, sendDone, nullRouteTrap;
  logic [7:0] adr_i, rxData;
  logic [3:0] sel_i;
  logic [15:0] sendVp, sendProc, sendCtx, crc, proc;
  logic [31:0] dat_i, dat_o, memAddr, ctxBlockAddr, lkAddr, sendRouteAddr, vptBase, rbase, off;
  logic [63:0] memWdata, memRdata, errData, lkRdata, routeWord, rd, hdr;
  logic [95:0] expw[$], gotw[$];
  logic [63:0] errq[$];
  logic [31:0] lkq[$];
  logic [7:0] ty = TX_WRITE;
  logic [7:0] ofs[4] = '{`NPIA_CTRL_OFS, `NPIA_FILTER_OFS, `NPIA_ROUTE_BASE_OFS, 8'h14};
  int bad_count = 0, samples_checked = 0, cycles = 0;
  int acks = 0, nacks = 0, lates = 0, dones = 0, traps = 0, ackWr = 0, e;
  npia_packet_input dut (.clk, .reset, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .stb_i, .cyc_i,
    .ack_o, .rxValid, .rxData, .rxDelim, .rxReady, .ackOut, .nackOut, .lateReject, .memReq,
    .memWe, .memAddr, .memWdata, .memAck, .memRdata, .errValid, .errData, .errReady, .sendReq,
    .sendVp, .ctxChange, .ctxBlockAddr, .lkReq, .lkAddr, .lkAck, .lkRdata, .lkBusy, .sendDone,
    .sendProc, .sendCtx, .sendRouteAddr, .nullRouteTrap);
  npia_link_sender far (.clk, .rxReady, .rxValid, .rxData, .rxDelim);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // memory and table partners stall at random
  always @(posedge clk) begin
    memAck <= memReq && !memAck && $urandom_range(0, 1);
    lkAck <= lkReq && !lkAck && $urandom_range(0, 1);
    errReady <= $urandom_range(0, 1);
    memRdata <= {$urandom, $urandom};
    lkRdata <= lkAddr == ctxBlockAddr ? {32'h0, vptBase} :
      lkAddr == vptBase + {13'h0, sendVp, 3'h0} ? {32'h0, proc, 16'h0077} : routeWord;
    if (memAck && memWe) gotw.push_back({memAddr, memWdata});
    if (lkAck) lkq.push_back(lkAddr);
    if (errValid && errReady) errq.push_back(errData);
    if (ackOut) ackWr = gotw.size();
    if (!reset) begin
      acks += ackOut;
      nacks += nackOut;
      lates += lateReject;
      dones += sendDone;
      traps += nullRouteTrap;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(string n, logic [95:0] x, logic [95:0] g);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk iff ack_o);
    rd = {32'h0, dat_o};
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic sb(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? `NPIA_CRC_POLY : 16'h0);
    far.put(1'b0, b);
  endtask
  task automatic txn(logic ap, logic [15:0] ctx, logic [2:0] n, logic bad, logic keep);
    logic [63:0] w;
    logic [31:0] a;
    logic [15:0] c;
    a = {16'h0, 13'($urandom), 3'h0};
    w = {ty, ap, 4'h0, n, ctx, a};
    hdr = w;
    crc = `NPIA_CRC_INIT;
    for (int k = 0; k <= n; k++) begin
      if (k > 0) w = {$urandom, $urandom};
      for (int i = 7; i >= 0; i--) sb(w[i*8+:8]);
      if (k > 0 && keep) expw.push_back({a + 32'(8 * (k - 1)), w});
    end
    c = crc ^ {15'h0, bad};
    sb(c[15:8]);
    sb(c[7:0]);
  endtask
  task automatic waitr(int n);
    for (int i = 0; i < 600 && (acks + nacks < n || memReq || errValid || !rxReady); i++)
      @(posedge clk);
    @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {reset, we_i, stb_i, cyc_i, memAck, errReady, sendReq, ctxChange, lkAck} = 9'h100;
    adr_i = 8'h0; dat_i = 32'h0; sel_i = 4'h0; sendVp = 16'h0; memRdata = 64'h0;
    lkRdata = 64'h0; ctxBlockAddr = 32'h100; vptBase = 32'h4000; proc = 16'h3;
    routeWord = 64'h2100_0000_0000_0000; rbase = 32'h8000;
    void'($urandom(98388));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (ofs[i]) begin
      wb(1'b0, ofs[i], 32'h0);
      chk("reset value", 96'h0, rd);
    end
    wb(1'b1, `NPIA_FILTER_OFS, 32'hbeef_1234);
    wb(1'b0, `NPIA_FILTER_OFS, 32'h0);
    chk("filter readback", 96'h1234, rd);
    $display("test registers done");
    for (int p = 0; p < 6; p++) begin
      repeat (p % 3) far.put(1'b0, 8'($urandom));
      far.put(1'b1, `NPIA_DELIM_START);
      txn(1'b1, 16'h0011, 3'(p % 4), 1'b0, 1'b1);
      e = expw.size();
      txn(1'b0, 16'h0011, 3'($urandom_range(0, 3)), 1'b0, 1'b1);
      far.put(1'b1, `NPIA_DELIM_END);
      far.rest();
      waitr(p + 1);
      chk("ack count", 96'(p + 1), 96'(acks));
      chk("ack after writes", 96'h1, 96'(ackWr >= e));
    end
    chk("nack count", 96'h0, 96'(nacks));
    chk("write count", 96'(expw.size()), 96'(gotw.size()));
    for (int i = 0; i < expw.size() && i < gotw.size(); i++) chk("write", expw[i], gotw[i]);
    $display("test good packets done");
    e = gotw.size();
    for (int m = 0; m < 3; m++) begin
      wb(1'b1, `NPIA_FILTER_OFS, 32'h0055);
      wb(1'b1, `NPIA_CTRL_OFS, m == 1 ? 32'h1 : m == 2 ? 32'h2 : 32'h0);
      far.put(1'b1, `NPIA_DELIM_START);
      txn(1'b1, 16'h0055, 3'h1, m == 0, 1'b0);
      far.put(1'b1, `NPIA_DELIM_END);
      far.rest();
      waitr(acks + m + 1);
      chk("nack count", 96'(m + 1), 96'(nacks));
    end
    chk("rejected writes", 96'(e), 96'(gotw.size()));
    wb(1'b1, `NPIA_CTRL_OFS, 32'h0);
    $display("test rejects done");
    e = acks;
    far.put(1'b1, `NPIA_DELIM_START);
    txn(1'b1, 16'h0011, 3'h0, 1'b0, 1'b1);
    txn(1'b0, 16'h0011, 3'h2, 1'b1, 1'b0);
    rd = hdr;
    txn(1'b0, 16'h0011, 3'h0, 1'b0, 1'b0);
    far.put(1'b1, `NPIA_DELIM_END);
    far.rest();
    waitr(e + 4);
    chk("late ack", 96'(e + 1), 96'(acks));
    chk("late nack", 96'h3, 96'(nacks));
    chk("late reject", 96'h1, 96'(lates));
    chk("error words", 96'h4, 96'(errq.size()));
    if (errq.size() > 0) chk("error head", rd, errq[0]);
    $display("test late reject done");
    ty = TX_COND;
    far.put(1'b1, `NPIA_DELIM_START);
    txn(1'b1, 16'h0011, 3'h1, 1'b0, 1'b0);
    far.put(1'b1, `NPIA_DELIM_END);
    far.rest();
    ty = TX_WRITE;
    waitr(acks + 4);
    chk("cond nack", 96'h4, 96'(nacks));
    $display("test conditional done");
    wb(1'b1, `NPIA_ROUTE_BASE_OFS, rbase);
    ctxChange <= 1'b1;
    @(posedge clk);
    ctxChange <= 1'b0;
    for (int i = 0; i < 300 && lkq.size() < 1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    for (int s = 1; s <= 2; s++) begin
      if (s == 2) routeWord = 64'h00ff_ffff_ffff_ffff;
      sendVp <= 16'($urandom);
      sendReq <= 1'b1;
      @(posedge clk);
      sendReq <= 1'b0;
      for (int i = 0; i < 300 && dones + traps < s; i++) @(posedge clk);
      @(posedge clk);
    end
    chk("table read", {64'h0, ctxBlockAddr}, 96'(lkq[0]));
    chk("process read", 96'(vptBase + {13'h0, sendVp, 3'h0}), 96'(lkq[3]));
    off = lkq[2] - rbase - {10'h0, proc, 6'h0};
    chk("route slot", 96'h0, 96'({off[31:6], off[3:0]}));
    chk("proc", 96'(proc), 96'(sendProc));
    chk("ctx", 96'h77, 96'(sendCtx));
    chk("done count", 96'h1, 96'(dones));
    chk("trap count", 96'h1, 96'(traps));
    $display("test lookup done");
    results();
  end
endmodule
